// ===== pkg/crc_pkg.sv
// Constants, types and helper functions for the stream CRC engine
package crc_pkg;

    localparam int unsigned BYTE_W       = 8;
    localparam int unsigned CRC_W_MAX    = 64;
    localparam int unsigned FIFO_DEPTH   = 16;
    localparam int unsigned CRC_W_32     = 32;

    // Generator polynomials, x^w term included
    localparam logic [32:0] GEN_POLY_32  = 33'h1_1edc_6f41;
    localparam logic [64:0] GEN_POLY_64  = 65'h1_ad93_d235_94c9_3659;

    localparam logic [63:0] MASK_64      = 64'hffff_ffff_ffff_ffff;
    localparam logic [63:0] MASK_32      = 64'h0000_0000_ffff_ffff;
    localparam logic [63:0] CRC_RST      = 64'h0000_0000_0000_0000;
    localparam logic [2:0]  LANE_MASK_32 = 3'h3;
    localparam logic [2:0]  LANE_MASK_64 = 3'h7;
    localparam logic [2:0]  BYTE_CNT_RST = 3'h0;
    localparam logic [2:0]  BYTE_CNT_INC = 3'h1;
    localparam logic [7:0]  PAD_BYTE     = 8'h00;

    typedef enum logic {
        CRC_WIDTH_32,
        CRC_WIDTH_64
    } crc_width_t;

    typedef logic [CRC_W_MAX-1:0] crc_word_t;

    // Reflected divisor: bit i holds the x^(w-1-i) coefficient
    function automatic crc_word_t reflect_poly(input crc_width_t w);
        crc_word_t r;
        r = CRC_RST;
        for (int i = 0; i < CRC_W_MAX; i++) begin
            if (w == CRC_WIDTH_64) begin
                r[i] = GEN_POLY_64[CRC_W_MAX-1-i];
            end else if (i < CRC_W_32) begin
                r[i] = GEN_POLY_32[CRC_W_32-1-i];
            end
        end
        return r;
    endfunction : reflect_poly

    function automatic crc_word_t width_mask(input crc_width_t w);
        return (w == CRC_WIDTH_64) ? MASK_64 : MASK_32;
    endfunction : width_mask

    // Complement within the selected width, upper bits cleared
    function automatic crc_word_t invert_w(input crc_width_t w, input crc_word_t v);
        return ~v & width_mask(w);
    endfunction : invert_w

    // True once the byte count is a whole number of w-bit words
    function automatic logic word_aligned(input crc_width_t w, input logic [2:0] cnt);
        return (cnt & ((w == CRC_WIDTH_64) ? LANE_MASK_64 : LANE_MASK_32)) == BYTE_CNT_RST;
    endfunction : word_aligned

endpackage : crc_pkg

// ===== pkg/byte_stream_if.sv
// Valid/ready stream carrier between the engine's own modules
`timescale 1ns/1ps
interface byte_stream_if #(
    parameter int unsigned DATA_W = 9
);
    logic              valid;
    logic              ready;
    logic [DATA_W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : byte_stream_if

// ===== hw/byte_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
    parameter int unsigned WIDTH = 9,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic   ref_clk, // Core clock
    input  wire logic   sys_rst, // Synchronous reset, active high
    byte_stream_if.snk  push,    // Filling side
    byte_stream_if.src  pop      // Draining side
);
    import crc_pkg::*;

    localparam int unsigned PTR_W = $clog2(DEPTH);
    localparam int unsigned CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_RST = '0;
    localparam logic [PTR_W-1:0] PTR_INC = PTR_W'(1);
    localparam logic [CNT_W-1:0] CNT_RST = '0;
    localparam logic [CNT_W-1:0] CNT_INC = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q, wr_ptr_d;
    logic [PTR_W-1:0] rd_ptr_q, rd_ptr_d;
    logic [CNT_W-1:0] count_q, count_d;
    logic             do_push;
    logic             do_pop;

    assign push.ready = (count_q != CNT_FULL);
    assign pop.valid  = (count_q != CNT_RST);
    assign pop.data   = mem[rd_ptr_q];
    assign do_push    = push.valid && push.ready;
    assign do_pop     = pop.valid && pop.ready;

    always_comb begin
        wr_ptr_d = do_push ? wr_ptr_q + PTR_INC : wr_ptr_q;
        rd_ptr_d = do_pop ? rd_ptr_q + PTR_INC : rd_ptr_q;
        count_d  = count_q;
        if (do_push && !do_pop) begin
            count_d = count_q + CNT_INC;
        end else if (do_pop && !do_push) begin
            count_d = count_q - CNT_INC;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_ptr_q <= PTR_RST;
            rd_ptr_q <= PTR_RST;
            count_q  <= CNT_RST;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem[wr_ptr_q] <= push.data;
        end
    end

    property p_fifo_full_stalls;
        @(posedge ref_clk) disable iff (sys_rst)
        (count_q == CNT_FULL) |-> !push.ready;
    endproperty
    a_fifo_full_stalls: assert property (p_fifo_full_stalls) else $error("fifo full but ready");

    property p_fifo_count_track;
        @(posedge ref_clk) disable iff (sys_rst)
        (do_push && !do_pop) |=> (count_q == $past(count_q) + CNT_INC);
    endproperty
    a_fifo_count_track: assert property (p_fifo_count_track) else $error("fifo count slip");

endmodule : byte_fifo

// ===== hw/crc_byte_step.sv
// One byte of reflected CRC division for the selected width
`timescale 1ns/1ps
module crc_byte_step (
    input  crc_pkg::crc_width_t width,    // Selected CRC width
    input  crc_pkg::crc_word_t  crc_in,   // Remainder before this byte
    input  wire logic [7:0]     data_in,  // Source byte
    output crc_pkg::crc_word_t  crc_out   // Remainder after this byte
);
    import crc_pkg::*;

    crc_word_t c;
    crc_word_t poly;
    logic      fb;

    always_comb begin
        poly = reflect_poly(width);
        c    = crc_in;
        fb   = 1'b0;
        // Bit 0 enters first: it is the highest message term
        for (int i = 0; i < BYTE_W; i++) begin
            fb = c[0] ^ data_in[i];
            c  = c >> 1;
            if (fb) begin
                c = c ^ poly;
            end
        end
        crc_out = c & width_mask(width);
    end

endmodule : crc_byte_step

// ===== hw/crc_stream_engine.sv
// Stream CRC engine: 32/64-bit reflected CRC over a buffered byte stream
`timescale 1ns/1ps

// Function
// - Width 32 or 64 is chosen per operation and drives every step.
// - The 32-bit mode divides by generator 0x11edc6f41.
// - The 64-bit mode divides by generator 0x1ad93d23594c93659.
// - Zero bytes are appended until the length is a multiple of w.
// - Bit 0 of the first byte is the highest message term.
// - The first w message bits are complemented before division.
// - Message times x^w is divided; the w-bit remainder is kept.
// - The remainder is complemented to form the reported CRC.
// - Result bit 0 of byte 0 holds the x^(w-1) coefficient.
// - The seed uses the same byte and bit layout as the result.
module crc_stream_engine (
    input  wire logic          ref_clk,      // Core clock, 200 MHz
    input  wire logic          sys_rst,      // Synchronous reset, active high
    input  wire logic          start_valid,  // Operation start request
    output logic               start_ready,  // Engine idle, start taken
    input  crc_pkg::crc_width_t start_width, // CRC width for the operation
    input  crc_pkg::crc_word_t start_seed,   // Seed, result layout
    input  wire logic          in_valid,     // Source byte valid
    output logic               in_ready,     // Buffer has room
    input  wire logic [7:0]    in_data,      // Source byte
    input  wire logic          in_last,      // Final byte of the transfer
    output logic               done,         // One-cycle completion strobe
    output crc_pkg::crc_word_t crc_result    // Final CRC, valid with done
);
    import crc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_PAD
    } eng_state_t;

    byte_stream_if #(.DATA_W(BYTE_W + 1)) push_if ();
    byte_stream_if #(.DATA_W(BYTE_W + 1)) pop_if ();

    eng_state_t  state_q, state_d;
    crc_width_t  width_q, width_d;
    crc_word_t   crc_q, crc_d;
    crc_word_t   result_q, result_d;
    logic [2:0]  cnt_q, cnt_d;
    logic        done_q, done_d;
    logic [2:0]  cnt_inc;
    logic [7:0]  step_byte;
    crc_word_t   step_crc;
    logic        take;
    logic        take_last;

    // Source bytes are buffered with their last flag on top
    assign push_if.valid = in_valid;
    assign push_if.data  = {in_last, in_data};
    assign in_ready      = push_if.ready;

    byte_fifo #(
        .WIDTH (BYTE_W + 1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .push    (push_if.snk),
        .pop     (pop_if.src)
    );

    // Engine drains only while a transfer is running
    assign pop_if.ready = (state_q == ST_RUN);
    assign take         = pop_if.valid && pop_if.ready;
    assign take_last    = take && pop_if.data[BYTE_W];
    assign cnt_inc      = cnt_q + BYTE_CNT_INC;
    assign start_ready  = (state_q == ST_IDLE);

    // Padding feeds zero bytes through the same divider
    assign step_byte = (state_q == ST_PAD) ? PAD_BYTE : pop_if.data[BYTE_W-1:0];

    crc_byte_step u_step (
        .width   (width_q),
        .crc_in  (crc_q),
        .data_in (step_byte),
        .crc_out (step_crc)
    );

    always_comb begin
        state_d  = state_q;
        width_d  = width_q;
        crc_d    = crc_q;
        cnt_d    = cnt_q;
        result_d = result_q;
        done_d   = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (start_valid) begin
                    width_d = start_width;
                    // Seed in result layout; complement preloads the inversion
                    crc_d   = invert_w(start_width, start_seed);
                    cnt_d   = BYTE_CNT_RST;
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (take) begin
                    crc_d = step_crc;
                    cnt_d = cnt_inc;
                    if (take_last) begin
                        if (word_aligned(width_q, cnt_inc)) begin
                            result_d = invert_w(width_q, step_crc);
                            done_d   = 1'b1;
                            state_d  = ST_IDLE;
                        end else begin
                            state_d = ST_PAD;
                        end
                    end
                end
            end
            ST_PAD: begin
                crc_d = step_crc;
                cnt_d = cnt_inc;
                if (word_aligned(width_q, cnt_inc)) begin
                    result_d = invert_w(width_q, step_crc);
                    done_d   = 1'b1;
                    state_d  = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q  <= ST_IDLE;
            width_q  <= CRC_WIDTH_32;
            crc_q    <= CRC_RST;
            result_q <= CRC_RST;
            cnt_q    <= BYTE_CNT_RST;
            done_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            width_q  <= width_d;
            crc_q    <= crc_d;
            result_q <= result_d;
            cnt_q    <= cnt_d;
            done_q   <= done_d;
        end
    end

    assign done       = done_q;
    assign crc_result = result_q;

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_start_taken;
        start_valid && start_ready;
    endsequence

    sequence s_last_taken;
        (state_q == ST_RUN) && take_last;
    endsequence

    property p_start_init;
        s_start_taken |=> (crc_q == invert_w(width_q, $past(start_seed)));
    endproperty
    a_start_init: assert property (p_start_init) else $error("seed not preloaded");

    property p_width_held;
        (state_q != ST_IDLE) |=> (state_q == ST_IDLE) || (width_q == $past(width_q));
    endproperty
    a_width_held: assert property (p_width_held) else $error("width changed mid run");

    property p_pad_zero;
        (state_q == ST_PAD) |-> (step_byte == PAD_BYTE);
    endproperty
    a_pad_zero: assert property (p_pad_zero) else $error("pad byte not zero");

    property p_done_aligned;
        done_q |-> word_aligned(width_q, cnt_q);
    endproperty
    a_done_aligned: assert property (p_done_aligned) else $error("length not word multiple");

    property p_done_pulse;
        done_q |=> !done_q;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

    property p_last_to_done;
        s_last_taken |=> ##[0:7] done_q;
    endproperty
    a_last_to_done: assert property (p_last_to_done) else $error("done missing after last");

    property p_result_inverted;
        done_q |-> (result_q == invert_w(width_q, crc_q));
    endproperty
    a_result_inverted: assert property (p_result_inverted) else $error("result not inverted");

    property p_result_narrow;
        (done_q && (width_q == CRC_WIDTH_32)) |-> ((result_q & ~MASK_32) == CRC_RST);
    endproperty
    a_result_narrow: assert property (p_result_narrow) else $error("upper bits set in 32 mode");

    property p_idle_no_pop;
        (state_q != ST_RUN) |-> !take;
    endproperty
    a_idle_no_pop: assert property (p_idle_no_pop) else $error("byte taken outside run");

    sequence s_pad_entry;
        (state_q == ST_RUN) && take_last && !word_aligned(width_q, cnt_inc);
    endsequence

    // Worst case: one byte in 64-bit mode needs seven pad steps
    sequence s_pad_to_done;
        (state_q == ST_PAD) ##[1:7] done_q;
    endsequence

    property p_start_to_run;
        s_start_taken |=> (state_q == ST_RUN);
    endproperty
    a_start_to_run: assert property (p_start_to_run) else $error("start not taken");

    property p_width_capture;
        s_start_taken |=> (width_q == $past(start_width));
    endproperty
    a_width_capture: assert property (p_width_capture) else $error("width not captured");

    property p_start_refused;
        (start_valid && !start_ready) |=> (width_q == $past(width_q));
    endproperty
    a_start_refused: assert property (p_start_refused) else $error("busy start taken");

    property p_cnt_cleared;
        s_start_taken |=> (cnt_q == BYTE_CNT_RST);
    endproperty
    a_cnt_cleared: assert property (p_cnt_cleared) else $error("byte count not cleared");

    property p_idle_holds_crc;
        ((state_q == ST_IDLE) && !start_valid) |=> $stable(crc_q);
    endproperty
    a_idle_holds_crc: assert property (p_idle_holds_crc) else $error("idle remainder moved");

    property p_byte_advances;
        ((state_q == ST_RUN) && take) |=> (crc_q == $past(step_crc));
    endproperty
    a_byte_advances: assert property (p_byte_advances) else $error("byte not divided");

    property p_byte_counted;
        ((state_q == ST_RUN) && take) |=> (cnt_q == $past(cnt_inc));
    endproperty
    a_byte_counted: assert property (p_byte_counted) else $error("byte not counted");

    property p_stall_holds;
        ((state_q == ST_RUN) && !take) |=>
            ($stable(crc_q) && $stable(cnt_q));
    endproperty
    a_stall_holds: assert property (p_stall_holds) else $error("stall moved remainder");

    property p_pad_entry;
        s_pad_entry |=> s_pad_to_done;
    endproperty
    a_pad_entry: assert property (p_pad_entry) else $error("padding did not finish");

    property p_aligned_last_done;
        ((state_q == ST_RUN) && take_last && word_aligned(width_q, cnt_inc)) |=>
            done_q;
    endproperty
    a_aligned_last_done: assert property (p_aligned_last_done) else $error("done late");

    property p_pad_advances;
        (state_q == ST_PAD) |=> (cnt_q == $past(cnt_inc)) && (crc_q == $past(step_crc));
    endproperty
    a_pad_advances: assert property (p_pad_advances) else $error("pad step lost");

    property p_pad_holds_off;
        ((state_q == ST_PAD) && !word_aligned(width_q, cnt_inc)) |=>
            ((state_q == ST_PAD) && !done_q);
    endproperty
    a_pad_holds_off: assert property (p_pad_holds_off) else $error("padding cut short");

    property p_pad_unaligned;
        (state_q == ST_PAD) |-> !word_aligned(width_q, cnt_q);
    endproperty
    a_pad_unaligned: assert property (p_pad_unaligned) else $error("pad past word end");

    property p_done_to_idle;
        done_q |-> (state_q == ST_IDLE);
    endproperty
    a_done_to_idle: assert property (p_done_to_idle) else $error("busy after done");

    property p_done_from_busy;
        done_q |-> ($past(state_q) != ST_IDLE);
    endproperty
    a_done_from_busy: assert property (p_done_from_busy) else $error("done while idle");

    property p_result_held;
        !done_q |-> $stable(result_q);
    endproperty
    a_result_held: assert property (p_result_held) else $error("result moved");

    property p_crc_narrow;
        ((state_q != ST_IDLE) && (width_q == CRC_WIDTH_32)) |->
            ((crc_q & ~MASK_32) == CRC_RST);
    endproperty
    a_crc_narrow: assert property (p_crc_narrow) else $error("upper remainder set");

endmodule : crc_stream_engine

// ===== verification/stream_feeder.sv
// Source-side model: start requests and source bytes for the CRC engine
`timescale 1ns/1ps
module stream_feeder (
    input  wire logic          ref_clk,     // Core clock
    input  wire logic          sys_rst,     // Synchronous reset, holds off requests
    output logic               start_valid, // Start request
    input  wire logic          start_ready, // Engine idle
    output crc_pkg::crc_width_t start_width, // Width for the operation
    output crc_pkg::crc_word_t start_seed,  // Seed in result layout
    output logic               in_valid,    // Byte valid
    input  wire logic          in_ready,    // Buffer room
    output logic [7:0]         in_data,     // Source byte
    output logic               in_last      // Final byte marker
);
    import crc_pkg::*;

    initial begin
        start_valid = 1'b0;
        start_width = CRC_WIDTH_32;
        start_seed  = CRC_RST;
        in_valid    = 1'b0;
        in_data     = 8'h00;
        in_last     = 1'b0;
    end

    // Called just after a rising edge; held until start_ready is seen high
    task automatic op_start(input crc_width_t w, input crc_word_t s);
        logic ok;
        while (sys_rst !== 1'b0) @(posedge ref_clk);
        start_valid <= 1'b1;
        start_width <= w;
        start_seed  <= s;
        // Ready is read settled, half a cycle before the edge that takes it
        do begin
            @(negedge ref_clk);
            ok = start_ready;
            @(posedge ref_clk);
        end while (ok !== 1'b1);
        start_valid <= 1'b0;
        start_seed  <= ~s;
    endtask : op_start

    // Gap cycles of idle between bytes model a slow source
    task automatic push(input logic [7:0] d[$], input int gap);
        logic ok;
        while (sys_rst !== 1'b0) @(posedge ref_clk);
        foreach (d[i]) begin
            in_valid <= 1'b1;
            in_data  <= d[i];
            in_last  <= (i == d.size() - 1);
            do begin
                @(negedge ref_clk);
                ok = in_ready;
                @(posedge ref_clk);
            end while (ok !== 1'b1);
            if (gap > 0 || i == d.size() - 1) begin
                in_valid <= 1'b0;
                in_last  <= 1'b0;
                in_data  <= ~d[i];
                repeat (gap) @(posedge ref_clk);
            end
        end
    endtask : push
endmodule : stream_feeder

// ===== verification/crc_stream_engine_tb.sv
// Self-checking testbench for the stream CRC engine
`timescale 1ns/1ps
module crc_stream_engine_tb;
    import crc_pkg::*;

    logic       ref_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       start_valid, start_ready, in_valid, in_ready, in_last, done;
    crc_width_t start_width;
    crc_word_t  start_seed, crc_result;
    logic [7:0] in_data;
    int         n_mismatch = 0;
    int         num_checks = 0;
    int         cyc = 0;

    crc_stream_engine crc_stream_engine_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .start_valid(start_valid), .start_ready(start_ready), .start_width(start_width),
        .start_seed(start_seed), .in_valid(in_valid), .in_ready(in_ready),
        .in_data(in_data), .in_last(in_last), .done(done), .crc_result(crc_result));
    stream_feeder stream_feeder_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .start_valid(start_valid), .start_ready(start_ready), .start_width(start_width),
        .start_seed(start_seed), .in_valid(in_valid), .in_ready(in_ready),
        .in_data(in_data), .in_last(in_last));

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk_crc(input crc_word_t got, input crc_word_t exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk_crc

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %b", $time, msg, got);
        end
    endtask : chk_bit

    // Bitwise reflected division, independent of the design's helpers
    function automatic crc_word_t ref_crc(input crc_width_t w, input crc_word_t s,
                                          input logic [7:0] d[$]);
        logic [64:0] g;
        crc_word_t   p, m, c;
        int          nb;
        nb = (w == CRC_WIDTH_64) ? 8 : 4;
        g  = (w == CRC_WIDTH_64) ? GEN_POLY_64 : {32'h0000_0000, GEN_POLY_32};
        m  = (w == CRC_WIDTH_64) ? MASK_64 : MASK_32;
        p  = CRC_RST;
        for (int i = 0; i < nb * 8; i++) p[i] = g[nb*8-1-i];
        c = ~s & m;
        while (d.size() % nb != 0) d.push_back(8'h00);
        foreach (d[j]) begin
            for (int b = 0; b < 8; b++) c = (c[0] ^ d[j][b]) ? ((c >> 1) ^ p) : (c >> 1);
        end
        return ~c & m;
    endfunction : ref_crc

    task automatic wait_done(output crc_word_t r);
        int k;
        k = 0;
        @(negedge ref_clk);
        chk_bit(start_ready, 1'b0, "busy after start");
        while (done !== 1'b1 && k < 200) begin
            @(negedge ref_clk);
            k++;
        end
        if (k >= 200) begin
            n_mismatch++;
            $display("[ERR] %0t no done", $time);
        end
        r = crc_result;
        @(negedge ref_clk);
        chk_bit(done, 1'b0, "done one cycle");
        chk_crc(crc_result, r, "result held");
        chk_bit(start_ready, 1'b1, "idle after done");
    endtask : wait_done

    task automatic run_op(input crc_width_t w, input crc_word_t s, input logic [7:0] d[$],
                          input int gap, output crc_word_t r);
        @(posedge ref_clk);
        // Done is watched from the start on, so a fast finish is not missed
        fork
            begin
                stream_feeder_i.op_start(w, s);
                wait_done(r);
            end
            stream_feeder_i.push(d, gap);
        join
    endtask : run_op

    task automatic t_check9;
        logic [7:0] d[$] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39};
        crc_word_t  r;
        run_op(CRC_WIDTH_32, CRC_RST, d, 0, r);
        chk_crc(r, ref_crc(CRC_WIDTH_32, CRC_RST, d), "ascii digits");
        $display("t_check9 done");
    endtask : t_check9

    task automatic t_lengths;
        int         lens[8] = '{1, 3, 4, 5, 7, 8, 9, 16};
        logic [7:0] d[$];
        crc_word_t  r, s;
        crc_width_t w;
        for (int wi = 0; wi < 2; wi++) begin
            for (int li = 0; li < 8; li++) begin
                w = crc_width_t'(wi);
                d.delete();
                for (int k = 0; k < lens[li]; k++) d.push_back(8'(k * 29 + li * 7 + 90));
                s = li[0] ? (64'h0123_4567_89ab_cdef & ((wi == 1) ? MASK_64 : MASK_32))
                          : CRC_RST;
                run_op(w, s, d, li % 3, r);
                chk_crc(r, ref_crc(w, s, d), "length sweep");
            end
        end
        $display("t_lengths done");
    endtask : t_lengths

    task automatic t_chain;
        logic [7:0] a[$] = '{8'h10, 8'h21, 8'h32, 8'h43, 8'h54, 8'h65, 8'h76, 8'h87};
        logic [7:0] b[$] = '{8'hf0, 8'he1, 8'hd2, 8'hc3, 8'hb4};
        crc_word_t  r1, r2;
        logic [7:0] ab[$];
        run_op(CRC_WIDTH_32, CRC_RST, a, 0, r1);
        chk_crc(r1, ref_crc(CRC_WIDTH_32, CRC_RST, a), "chain head");
        run_op(CRC_WIDTH_32, r1, b, 0, r2);
        ab = a;
        foreach (b[i]) ab.push_back(b[i]);
        chk_crc(r2, ref_crc(CRC_WIDTH_32, CRC_RST, ab), "chained seed");
        $display("t_chain done");
    endtask : t_chain

    task automatic t_fill;
        logic [7:0] d[$];
        crc_word_t  r;
        for (int k = 0; k < 20; k++) d.push_back(8'(k * 59 + 3));
        @(posedge ref_clk);
        fork
            stream_feeder_i.push(d, 1);
        join_none
        repeat (40) @(posedge ref_clk);
        @(negedge ref_clk);
        chk_bit(in_ready, 1'b0, "fifo full");
        @(posedge ref_clk);
        stream_feeder_i.op_start(CRC_WIDTH_64, CRC_RST);
        wait_done(r);
        wait fork;
        chk_crc(r, ref_crc(CRC_WIDTH_64, CRC_RST, d), "buffered stream");
        chk_bit(in_ready, 1'b1, "fifo drained");
        $display("t_fill done");
    endtask : t_fill

    initial begin
        forever begin
            @(posedge ref_clk);
            cyc++;
            if (cyc >= 20000) begin
                n_mismatch++;
                $display("[ERR] %0t timeout", $time);
                tally_and_finish();
            end
        end
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_check9();
        t_lengths();
        t_chain();
        t_fill();
        tally_and_finish();
    end
endmodule : crc_stream_engine_tb
